/* File: src/pmsc_device.sv */
// Purpose: start/stop sequencer, reset pulses and two-wire register slave
// Assumes: supply comparators, pins and link arrive asynchronously
// Notes: slow timebase is a one-cycle tick from a divider
//
// Design decision made here: the two-wire slave interface to the registers.
`timescale 1ns/1ps
module pmsc_device #(
  parameter int TICK_DIV = pmsc_pkg::TICK_DIV,
  parameter int TRRST_CYC = pmsc_pkg::TRRST_CYC,
  parameter int TOFF_CYC = pmsc_pkg::TOFF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  pmsc_link_if.device link,
  input wire logic main_supply_start_ok,
  input wire logic main_supply_low,
  input wire logic power_on_request_pin,
  input wire logic over_temp_flag,
  input wire logic regulator_gate_a,
  input wire logic regulator_gate_b,
  input wire logic crystal_clk_in,
  output logic buck_boost_en,
  output logic buck_one_en,
  output logic buck_two_en,
  output logic first_reset_out_n,
  output logic linear_regulator_four,
  output logic second_reset_out_n,
  output logic linear_regulator_two,
  output logic linear_regulator_three,
  output logic linear_regulator_one,
  output logic slow_clock_out
);
  // synchroniser lanes
  localparam int I_START = 0;
  localparam int I_LOW = 1;
  localparam int I_PON = 2;
  localparam int I_OTP = 3;
  localparam int I_GA = 4;
  localparam int I_GB = 5;
  localparam int I_SCL = 6;
  localparam int I_SDA = 7;
  localparam int I_XTAL = 8;
  // output lanes, in start order
  localparam int O_RST1 = 3;
  localparam int O_LINEAR_REGULATOR_FOUR = 4;
  localparam int O_RST2 = 5;
  localparam int N_OUT = 9;

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic scl_q;
    logic sda_q;
    pmsc_pkg::pmsc_islv_t ist;
    logic [3:0] bc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic rd_go;
    logic mack;
    logic sda_oe;
    logic [1:0] hsel;
    logic hreq;
    logic hdet;
    logic [1:0] rsel;
    logic rreq;
    logic [9:0] tdiv;
    logic tick;
    logic [11:0] hcnt;
    logic [11:0] rcnt;
    logic run;
    logic supply_running_flag;
    logic [3:0] lvl;
    logic [19:0] scnt;
    logic [8:0] outs;
    logic xclk;
  } pmsc_dev_t;

  pmsc_dev_t s;
  pmsc_dev_t n;

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic scl_r;
    logic scl_f;
    logic sta;
    logic sto;
    logic rrise;
    logic [7:0] rdat;
    logic [19:0] lim;
    scl_r = 1'b0;
    scl_f = 1'b0;
    sta = 1'b0;
    sto = 1'b0;
    rrise = 1'b0;
    rdat = 8'h00;
    lim = 20'(TOFF_CYC - 1);
    n = s;
    n.s1 = {crystal_clk_in, link.sda, link.scl, regulator_gate_b,
      regulator_gate_a, over_temp_flag, power_on_request_pin,
      main_supply_low, main_supply_start_ok};
    n.s2 = s.s1;
    n.scl_q = s.s2[I_SCL];
    n.sda_q = s.s2[I_SDA];
    n.xclk = s.s2[I_XTAL];
    // line events
    scl_r = s.s2[I_SCL] & ~s.scl_q;
    scl_f = ~s.s2[I_SCL] & s.scl_q;
    sta = s.s2[I_SCL] & s.scl_q & s.sda_q & ~s.s2[I_SDA];
    sto = s.s2[I_SCL] & s.scl_q & ~s.sda_q & s.s2[I_SDA];
    // read view of the register at the pointer
    case (s.ptr)
      pmsc_pkg::ADDR_HARD_RESET: begin
        rdat[pmsc_pkg::BIT_HIST] = s.hdet;
        rdat[pmsc_pkg::BIT_SEL_LO +: 2] = s.hsel;
        rdat[pmsc_pkg::BIT_REQ] = s.hreq;
      end
      pmsc_pkg::ADDR_RESTART: begin
        rdat[pmsc_pkg::BIT_SEL_LO +: 2] = s.rsel;
        rdat[pmsc_pkg::BIT_REQ] = s.rreq;
      end
      pmsc_pkg::ADDR_STATE: rdat[pmsc_pkg::BIT_RUN] = s.supply_running_flag;
      default: rdat = 8'h00;
    endcase
    // slave byte engine, never drives the clock line
    if (sta) begin
      n.ist = pmsc_pkg::PMSC_I_ADDR;
      n.bc = 4'h0;
      n.sda_oe = 1'b0;
    end else if (sto) begin
      n.ist = pmsc_pkg::PMSC_I_IDLE;
      n.sda_oe = 1'b0;
    end else if (s.ist != pmsc_pkg::PMSC_I_IDLE) begin
      if (scl_r) begin
        if (s.bc < 4'h8) begin
          n.sh = {s.sh[6:0], s.s2[I_SDA]};
        end
        n.mack = ~s.s2[I_SDA];
        n.bc = s.bc + 4'h1;
      end else if (scl_f) begin
        n.sda_oe = 1'b0;
        if (s.bc == 4'h8) begin
          case (s.ist)
            pmsc_pkg::PMSC_I_ADDR: begin
              if (s.sh[7:1] == pmsc_pkg::SLAVE_ADDR) begin
                n.sda_oe = 1'b1;
                n.rd_go = s.sh[0];
                n.ist = s.sh[0] ? pmsc_pkg::PMSC_I_RD : pmsc_pkg::PMSC_I_REG;
              end else begin
                n.ist = pmsc_pkg::PMSC_I_IDLE;
              end
            end
            pmsc_pkg::PMSC_I_REG: begin
              n.ptr = s.sh;
              n.sda_oe = 1'b1;
              n.ist = pmsc_pkg::PMSC_I_WR;
            end
            pmsc_pkg::PMSC_I_WR: begin
              if (s.ptr != pmsc_pkg::ADDR_STATE) begin
                n.sda_oe = 1'b1;
                if (s.ptr != pmsc_pkg::ADDR_LAST) begin
                  n.ptr = s.ptr + 8'h01;
                end
              end
              if (s.ptr == pmsc_pkg::ADDR_HARD_RESET) begin
                n.hsel = s.sh[pmsc_pkg::BIT_SEL_LO +: 2];
                if (!s.sh[pmsc_pkg::BIT_HIST]) begin
                  n.hdet = 1'b0;
                end
                if (s.sh[pmsc_pkg::BIT_REQ] & ~s.hreq) begin
                  n.hreq = 1'b1;
                  n.hdet = 1'b1;
                end
              end
              if (s.ptr == pmsc_pkg::ADDR_RESTART) begin
                n.rsel = s.sh[pmsc_pkg::BIT_SEL_LO +: 2];
                if (s.sh[pmsc_pkg::BIT_REQ] & ~s.rreq) begin
                  n.rreq = 1'b1;
                  rrise = 1'b1;
                end
              end
            end
            default: n.sda_oe = 1'b0;
          endcase
        end else if (s.bc == 4'h9) begin
          n.bc = 4'h0;
          if (s.ist == pmsc_pkg::PMSC_I_RD) begin
            if (s.rd_go | s.mack) begin
              n.tx = rdat;
              n.rd_go = 1'b0;
              n.sda_oe = ~rdat[7];
              if (s.ptr != pmsc_pkg::ADDR_LAST) begin
                n.ptr = s.ptr + 8'h01;
              end
            end else begin
              n.ist = pmsc_pkg::PMSC_I_IDLE;
            end
          end
        end else if (s.ist == pmsc_pkg::PMSC_I_RD) begin
          n.sda_oe = ~s.tx[~s.bc[2:0]];
        end
      end
    end
    // slow tick divider
    n.tick = 1'b0;
    if (s.tdiv == 10'(TICK_DIV - 1)) begin
      n.tdiv = 10'h000;
      n.tick = 1'b1;
    end else begin
      n.tdiv = s.tdiv + 10'h001;
    end
    // hard-reset pulse timer
    if (s.hreq) begin
      if (s.hcnt == pmsc_pkg::sel_ticks(s.hsel)) begin
        n.hreq = 1'b0;
        n.hcnt = 12'h000;
      end else if (s.tick) begin
        n.hcnt = s.hcnt + 12'h001;
      end
    end
    // restart off-interval, counted once fully stopped
    if (s.rreq && s.lvl == 4'h0) begin
      if (s.rcnt == pmsc_pkg::sel_ticks(s.rsel)) begin
        n.rreq = 1'b0;
        n.rcnt = 12'h000;
      end else if (s.tick) begin
        n.rcnt = s.rcnt + 12'h001;
      end
    end
    // run state with hysteresis between the two supply levels
    if (s.s2[I_START] & s.s2[I_PON]) begin
      n.supply_running_flag = 1'b1;
    end else if (s.s2[I_LOW] | ~s.s2[I_PON]) begin
      n.supply_running_flag = 1'b0;
    end
    if (s.s2[I_LOW] | ~s.s2[I_PON] | s.s2[I_OTP] | rrise) begin
      n.run = 1'b0;
    end else if (s.s2[I_START] & s.s2[I_PON] & ~s.rreq) begin
      n.run = 1'b1;
    end
    // sequencer steps one level per delay
    if (s.run && s.lvl == pmsc_pkg::LVL_RST2 - 4'h1) begin
      lim = 20'(TRRST_CYC - 1);
    end
    if (s.run ? (s.lvl != pmsc_pkg::LVL_FULL) : (s.lvl != 4'h0)) begin
      n.scnt = s.scnt + 20'h00001;
      if (s.scnt >= lim) begin
        n.scnt = 20'h00000;
        n.lvl = s.run ? s.lvl + 4'h1 : s.lvl - 4'h1;
      end
    end else begin
      n.scnt = 20'h00000;
    end
    // outputs from the new level
    for (int k = 0; k < N_OUT; k++) begin
      n.outs[k] = n.lvl > 4'(k);
    end
    n.outs[O_RST2] = n.outs[O_RST2] & ~n.hreq;
    if (n.outs[O_RST1] & n.outs[O_RST2]) begin
      n.outs[O_LINEAR_REGULATOR_FOUR] = n.outs[O_LINEAR_REGULATOR_FOUR] & s.s2[I_GA];
      n.outs[N_OUT-1:O_RST2+1] = n.outs[N_OUT-1:O_RST2+1]
        & {3{s.s2[I_GA] & s.s2[I_GB]}};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign buck_boost_en = s.outs[0];
  assign buck_one_en = s.outs[1];
  assign buck_two_en = s.outs[2];
  assign first_reset_out_n = s.outs[O_RST1];
  assign linear_regulator_four = s.outs[O_LINEAR_REGULATOR_FOUR];
  assign second_reset_out_n = s.outs[O_RST2];
  assign linear_regulator_two = s.outs[6];
  assign linear_regulator_three = s.outs[7];
  assign linear_regulator_one = s.outs[8];
  assign slow_clock_out = s.xclk;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = s.sda_oe;
endmodule

/* File: src/pmsc_host.sv */
// Purpose: two-wire master taking single-byte commands over AXI4-Lite
// Assumes: one device on the link, no clock stretching
// Notes: one register write or one register read per command
`timescale 1ns/1ps
module pmsc_host #(
  parameter int QTR_CYC = pmsc_pkg::QTR_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  pmsc_link_if.host link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  typedef struct packed {
    logic haw;
    logic hw;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic arr;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [23:0] cmd;
    pmsc_pkg::pmsc_hst_t hst;
    logic [6:0] qc;
    logic [1:0] q;
    logic [3:0] bc;
    logic [1:0] bi;
    logic [7:0] rx;
    logic nack;
    logic busy;
    logic scl_oe;
    logic sda_oe;
    logic s1;
    logic s2;
  } pmsc_host_t;

  pmsc_host_t s;
  pmsc_host_t n;

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0] tx;
    logic [31:0] stat;
    logic rdc;
    tx = 8'h00;
    stat = 32'h0;
    n = s;
    n.s1 = link.sda;
    n.s2 = s.s1;
    rdc = s.cmd[pmsc_pkg::CMD_RD];
    // bus slave: address and data taken in either order
    if (s_axi_awvalid & s.awr) begin
      n.haw = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid & s.wr) begin
      n.hw = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    if (s.haw & s.hw & ~s.bv) begin
      n.bv = 1'b1;
      n.br = pmsc_pkg::RESP_OKAY;
      if (s.awa == pmsc_pkg::HOST_CMD) begin
        if (!s.busy) begin
          for (int b = 0; b < 3; b++) begin
            if (s.ws[b]) begin
              n.cmd[b*8 +: 8] = s.wd[b*8 +: 8];
            end
          end
          n.busy = 1'b1;
          n.nack = 1'b0;
          n.bi = 2'h0;
          n.q = 2'h0;
          n.qc = 7'h00;
          n.hst = pmsc_pkg::PMSC_H_START;
        end
      end else if (s.awa != pmsc_pkg::HOST_STAT) begin
        n.br = pmsc_pkg::RESP_SLVERR;
      end
    end
    if (s.bv & s_axi_bready) begin
      n.bv = 1'b0;
      n.haw = 1'b0;
      n.hw = 1'b0;
    end
    // status view and read channel
    stat[pmsc_pkg::STAT_BUSY] = s.busy;
    stat[pmsc_pkg::STAT_NACK] = s.nack;
    stat[pmsc_pkg::STAT_RX_LO +: 8] = s.rx;
    if (s.rv & s_axi_rready) begin
      n.rv = 1'b0;
    end
    if (s_axi_arvalid & s.arr) begin
      n.rv = 1'b1;
      n.rr = pmsc_pkg::RESP_OKAY;
      n.rd = 32'h0;
      if (s_axi_araddr == pmsc_pkg::HOST_STAT) begin
        n.rd = stat;
      end else if (s_axi_araddr == pmsc_pkg::HOST_CMD) begin
        n.rd = {8'h00, s.cmd};
      end else begin
        n.rr = pmsc_pkg::RESP_SLVERR;
      end
    end
    n.awr = ~n.haw;
    n.wr = ~n.hw;
    n.arr = ~n.rv;
    // byte to send for the current slot
    case (s.bi)
      2'h0: tx = {pmsc_pkg::SLAVE_ADDR, 1'b0};
      2'h1: tx = s.cmd[pmsc_pkg::CMD_REG_LO +: 8];
      default: tx = rdc ? {pmsc_pkg::SLAVE_ADDR, 1'b1}
        : s.cmd[pmsc_pkg::CMD_DATA_LO +: 8];
    endcase
    // link master, four quarter steps per bit
    if (s.hst != pmsc_pkg::PMSC_H_IDLE) begin
      n.qc = s.qc + 7'h01;
      if (s.qc == 7'(QTR_CYC - 1)) begin
        n.qc = 7'h00;
        n.q = s.q + 2'h1;
        case (s.hst)
          pmsc_pkg::PMSC_H_START: begin
            case (s.q)
              2'h0: n.sda_oe = 1'b0;
              2'h1: n.scl_oe = 1'b0;
              2'h2: n.sda_oe = 1'b1;
              default: begin
                n.scl_oe = 1'b1;
                n.bc = 4'h0;
                n.hst = pmsc_pkg::PMSC_H_BYTE;
              end
            endcase
          end
          pmsc_pkg::PMSC_H_BYTE: begin
            case (s.q)
              2'h0: n.sda_oe = (s.bc < 4'h8 && s.bi != 2'h3)
                ? ~tx[~s.bc[2:0]] : 1'b0;
              2'h1: n.scl_oe = 1'b0;
              2'h2: begin
                if (s.bc < 4'h8) begin
                  n.rx = {s.rx[6:0], s.s2};
                end else if (s.bi != 2'h3) begin
                  n.nack = s.s2;
                end
              end
              default: begin
                n.scl_oe = 1'b1;
                n.bc = s.bc + 4'h1;
                if (s.bc == 4'h8) begin
                  n.bc = 4'h0;
                  n.bi = s.bi + 2'h1;
                  if (s.nack || s.bi == 2'h3 || (s.bi == 2'h2 && !rdc)) begin
                    n.hst = pmsc_pkg::PMSC_H_STOP;
                  end else if (s.bi == 2'h1 && rdc) begin
                    n.hst = pmsc_pkg::PMSC_H_START;
                  end
                end
              end
            endcase
          end
          default: begin
            case (s.q)
              2'h0: n.sda_oe = 1'b1;
              2'h1: n.scl_oe = 1'b0;
              2'h2: n.sda_oe = 1'b0;
              default: begin
                n.busy = 1'b0;
                n.hst = pmsc_pkg::PMSC_H_IDLE;
              end
            endcase
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awr;
  assign s_axi_wready = s.wr;
  assign s_axi_bvalid = s.bv;
  assign s_axi_bresp = s.br;
  assign s_axi_arready = s.arr;
  assign s_axi_rvalid = s.rv;
  assign s_axi_rdata = s.rd;
  assign s_axi_rresp = s.rr;
  assign link.scl_o = 1'b0;
  assign link.scl_oe = s.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = s.sda_oe;
endmodule

/* File: src/pmsc_link_if.sv */
// Purpose: open-drain two-wire link between host and device
// Assumes: pull-ups on both lines
// Notes: a line is low while any enabled driver outputs low
`timescale 1ns/1ps
interface pmsc_link_if;
  logic scl_o;
  logic scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire scl;
  wire sda;
  // wired-and resolution of the two lines
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output scl_o, output scl_oe,
    output host_sda_o, output host_sda_oe);
endinterface

/* File: src/pmsc_pkg.sv */
// Purpose: shared constants for the start/stop controller and its host
// Assumes: 125 MHz system clock, open-drain two-wire link
// Notes: device map, timing figures and host register map
package pmsc_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_MHZ = 125;
  //////////////////////////////////////////////////////////////////////////
  // device link identity and register map
  localparam logic [6:0] SLAVE_ADDR = 7'h2a;
  localparam logic [7:0] ADDR_HARD_RESET = 8'h03;
  localparam logic [7:0] ADDR_RESTART = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h05;
  localparam logic [7:0] ADDR_LAST = 8'hff;
  localparam int BIT_REQ = 0;
  localparam int BIT_RUN = 0;
  localparam int BIT_SEL_LO = 4;
  localparam int BIT_HIST = 7;
  //////////////////////////////////////////////////////////////////////////
  // timing: slow internal timebase and sequence delays
  localparam int TICK_KHZ = 140;
  localparam int TICK_DIV = CLK_HZ / (TICK_KHZ * 1000);
  localparam int HOLD0_US = 1000;
  localparam int HOLD1_US = 4000;
  localparam int HOLD2_US = 8000;
  localparam int HOLD3_US = 16000;
  localparam int TRRST_US = 5000;
  localparam int TRRST_CYC = TRRST_US * CLK_MHZ;
  localparam int TOFF_US = 200;
  localparam int TOFF_CYC = TOFF_US * CLK_MHZ;
  localparam int LINK_HZ = 400_000;
  localparam int QTR_CYC = (CLK_HZ + 4 * LINK_HZ - 1) / (4 * LINK_HZ);
  // sequence levels: output k is on while level > k
  localparam logic [3:0] LVL_RST2 = 4'h6;
  localparam logic [3:0] LVL_FULL = 4'h9;
  //////////////////////////////////////////////////////////////////////////
  // host register map
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STAT = 8'h04;
  localparam int CMD_REG_LO = 0;
  localparam int CMD_DATA_LO = 8;
  localparam int CMD_RD = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_RX_LO = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PMSC_I_IDLE = 3'b000,
    PMSC_I_ADDR = 3'b001,
    PMSC_I_REG = 3'b010,
    PMSC_I_WR = 3'b011,
    PMSC_I_RD = 3'b100
  } pmsc_islv_t;

  typedef enum logic [1:0] {
    PMSC_H_IDLE = 2'b00,
    PMSC_H_START = 2'b01,
    PMSC_H_BYTE = 2'b10,
    PMSC_H_STOP = 2'b11
  } pmsc_hst_t;

  // interval in slow ticks for a two-bit select code
  function automatic logic [11:0] sel_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: sel_ticks = 12'(HOLD0_US * TICK_KHZ / 1000);
      2'h1: sel_ticks = 12'(HOLD1_US * TICK_KHZ / 1000);
      2'h2: sel_ticks = 12'(HOLD2_US * TICK_KHZ / 1000);
      default: sel_ticks = 12'(HOLD3_US * TICK_KHZ / 1000);
    endcase
  endfunction
endpackage

/* File: test/pmsc_props.sv */
// Purpose: checker for device outputs and the link beside it
// Assumes: short counts, TOFF_CYC 20, gate pins steady for a while
// Notes: one clock domain, synchronous active-low reset
`timescale 1ns/1ps
module pmsc_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic dev_sda_oe,
  input wire logic buck_boost_en,
  input wire logic buck_one_en,
  input wire logic first_reset_out_n,
  input wire logic linear_regulator_four,
  input wire logic second_reset_out_n,
  input wire logic linear_regulator_one,
  input wire logic regulator_gate_a,
  input wire logic regulator_gate_b
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // sequencing
  a_reset_all_off: assert property (disable iff (1'b0)
    !rst_n |=> !buck_boost_en && !first_reset_out_n && !dev_sda_oe)
    else $error("on after reset");
  a_order_rails: assert property (buck_one_en |-> buck_boost_en)
    else $error("rail order broken");
  a_order_resets: assert property (
    linear_regulator_four |-> first_reset_out_n)
    else $error("reset order broken");
  a_step_delay: assert property ($rose(buck_one_en) |->
    $past(buck_boost_en, 15) && !$past(buck_boost_en, 25))
    else $error("step spacing");
  ////////////////////////////////////////////////////////////////////////
  // gate pins with both resets released
  a_gate_off: assert property (
    (first_reset_out_n && second_reset_out_n && !regulator_gate_a)[*6]
    |-> !linear_regulator_four && !linear_regulator_one)
    else $error("on with gate a low");
  a_gate_a_only: assert property ((first_reset_out_n &&
    second_reset_out_n && regulator_gate_a && !regulator_gate_b)[*6]
    |-> linear_regulator_four && !linear_regulator_one)
    else $error("gate a only wrong");
  ////////////////////////////////////////////////////////////////////////
  // data line moves only while clock line low
  a_drive_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("drive at clock high");
  a_release_scl_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("release at clock high");
  c_pulse: cover property ($fell(second_reset_out_n) && first_reset_out_n);
  c_answer: cover property ($rose(dev_sda_oe));
  c_full_on: cover property ($rose(linear_regulator_one));
endmodule

/* File: test/pmsc_start_stop_i2c_control_tb.sv */
// Purpose: bench for the start/stop controller and its link host
// Assumes: tick divider 4, short sequence steps, quarter bit of 8
// Notes: every device access runs through the host registers
`timescale 1ns/1ps
module pmsc_start_stop_i2c_control_tb;
  logic clk_sys, rst_n, main_supply_start_ok, main_supply_low;
  logic power_on_request_pin, over_temp_flag, crystal_clk_in;
  logic regulator_gate_a, regulator_gate_b, slow_clock_out;
  logic buck_boost_en, buck_one_en, buck_two_en, first_reset_out_n;
  logic linear_regulator_four, second_reset_out_n, linear_regulator_two;
  logic linear_regulator_three, linear_regulator_one;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail, n_tests, r2_low, bb_low;
  int us[4] = '{1000, 4000, 8000, 16000};
  pmsc_link_if lk();
  pmsc_device #(.TICK_DIV(4), .TRRST_CYC(200), .TOFF_CYC(20)) u_pmsc_device (
    .*, .link(lk.device));
  pmsc_host #(.QTR_CYC(8)) u_pmsc_host (.*, .link(lk.host));
  pmsc_props u_pmsc_props (.*, .scl(lk.scl), .dev_sda_oe(lk.dev_sda_oe));
  ////////////////////////////////////////////////////////////////////////
  // clock and low-time counters
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    r2_low <= r2_low + 32'(!second_reset_out_n);
    bb_low <= bb_low + 32'(!buck_boost_en);
  end
  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic till(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk("level", 8'(s), 8'(v));
  endtask
  // one bus access; each valid stands until its ready edge
  task automatic ax(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] d, output logic [1:0] rp);
    logic ra, rw, ok;
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    do begin
      @(negedge clk_sys);
      ra = wr ? s_axi_awready : s_axi_arready;
      rw = s_axi_wready;
      ok = wr ? s_axi_bvalid : s_axi_rvalid;
      d = s_axi_rdata;
      rp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_sys);
      if (ra) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (rw) s_axi_wvalid <= 1'b0;
      n++;
    end while (ok !== 1'b1 && n < 100);
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (ok !== 1'b1) n_fail++;
  endtask
  // one link transfer, then check data or nack
  task automatic xf(input logic rd, input logic [7:0] r, v, e);
    logic [31:0] s;
    logic [1:0] rp;
    int n;
    n = 0;
    ax(1'b1, pmsc_pkg::HOST_CMD, {15'h0, rd, v, r}, s, rp);
    do begin
      ax(1'b0, pmsc_pkg::HOST_STAT, 32'h0, s, rp);
      n++;
    end while (s[0] !== 1'b0 && n < 2000);
    if (rd) chk("read", s[15:8], e);
    else chk("nack", 8'(s[1]), e);
  endtask
  task automatic pins(input logic on, lo, hot);
    @(posedge clk_sys);
    power_on_request_pin <= on;
    main_supply_start_ok <= !lo;
    main_supply_low <= lo;
    over_temp_flag <= hot;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_power();
    int c;
    pins(1'b1, 1'b0, 1'b0);
    till(first_reset_out_n, 1'b1, 2000);
    c = r2_low;
    till(second_reset_out_n, 1'b1, 2000);
    chk("rst2 hold", 8'((r2_low - c) inside {[215:228]}), 8'h01);
    till(linear_regulator_one, 1'b1, 2000);
    chk("rails", {buck_boost_en, buck_one_en, buck_two_en,
      linear_regulator_four, linear_regulator_two, linear_regulator_three,
      first_reset_out_n, second_reset_out_n}, 8'hff);
    xf(1'b1, pmsc_pkg::ADDR_STATE, 8'h00, 8'h01);
    $display("test power done");
  endtask
  task automatic t_gate();
    logic [5:0] g[5] = '{6'h3f, 6'h21, 6'h00, 6'h10, 6'h3f};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      regulator_gate_a <= g[i][5];
      regulator_gate_b <= g[i][4];
      repeat (8) @(negedge clk_sys);
      chk("gates", {4'h0, linear_regulator_one, linear_regulator_two,
        linear_regulator_three, linear_regulator_four}, {4'h0, g[i][3:0]});
    end
    $display("test gate done");
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] rp;
    xf(1'b0, pmsc_pkg::ADDR_STATE, 8'h00, 8'h01);
    xf(1'b1, pmsc_pkg::ADDR_STATE, 8'h00, 8'h01);
    xf(1'b0, 8'h10, 8'h5a, 8'h00);
    xf(1'b1, 8'h10, 8'h00, 8'h00);
    xf(1'b1, pmsc_pkg::ADDR_LAST, 8'h00, 8'h00);
    xf(1'b0, pmsc_pkg::ADDR_RESTART, 8'h7e, 8'h00);
    xf(1'b1, pmsc_pkg::ADDR_RESTART, 8'h00, 8'h30);
    ax(1'b0, 8'h08, 32'h0, d, rp);
    chk("resp", 8'(rp), 8'(pmsc_pkg::RESP_SLVERR));
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      crystal_clk_in <= i[0];
      repeat (6) @(negedge clk_sys);
      chk("slow clk", 8'(slow_clock_out), 8'(i[0]));
    end
    $display("test regs done");
  endtask
  // hard pulse, then restart, over every select code
  task automatic t_timed(input logic [7:0] r);
    int c, t;
    logic rs;
    rs = r == pmsc_pkg::ADDR_RESTART;
    for (int i = 0; i < 4; i++) begin
      t = us[i] * pmsc_pkg::TICK_KHZ / 1000 * 4;
      c = rs ? bb_low : r2_low;
      xf(1'b0, r, {2'h0, i[1:0], 4'h1}, 8'h00);
      if (rs) begin
        till(buck_boost_en, 1'b0, 400);
        till(linear_regulator_one, 1'b1, 20000);
        chk("off", 8'((bb_low - c) inside {[t:t+48]}), 8'h01);
        xf(1'b1, r, 8'h00, {2'h0, i[1:0], 4'h0});
      end else begin
        till(second_reset_out_n, 1'b0, 400);
        till(second_reset_out_n, 1'b1, 20000);
        chk("pulse", 8'((r2_low - c) inside {[t-8:t+8]}), 8'h01);
        xf(1'b1, r, 8'h00, {2'h2, i[1:0], 4'h0});
      end
    end
    $display("test timed done");
  endtask
  task automatic t_stop();
    for (int i = 0; i < 3; i++) begin
      pins(i != 0, i == 1, i == 2);
      till(buck_boost_en, 1'b0, 1000);
      if (i < 2) xf(1'b1, pmsc_pkg::ADDR_STATE, 8'h00, 8'h00);
      pins(1'b1, 1'b0, 1'b0);
      till(linear_regulator_one, 1'b1, 3000);
    end
    $display("test stop done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // verdict, watchdog and main sequence
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
  initial begin
    {n_fail, n_tests, r2_low, bb_low} = '0;
    {rst_n, main_supply_start_ok, main_supply_low, power_on_request_pin,
      over_temp_flag, crystal_clk_in, s_axi_awvalid, s_axi_wvalid,
      s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
      s_axi_araddr, s_axi_wdata} = '0;
    {regulator_gate_a, regulator_gate_b, s_axi_wstrb} = '1;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_power();
    t_gate();
    t_regs();
    t_timed(pmsc_pkg::ADDR_HARD_RESET);
    t_timed(pmsc_pkg::ADDR_RESTART);
    t_stop();
    summarize();
  end
endmodule
